// [dsht_cfg.svh]
// Register offsets, field positions, reset values and limits of the link timing block
`ifndef DSHT_CFG_SVH
`define DSHT_CFG_SVH
`define DSHT_A_STAT 16'hb804
`define DSHT_A_IEN 16'hb808
`define DSHT_A_FSET 16'hb80c
`define DSHT_A_HSTO 16'hb810
`define DSHT_A_LPTO 16'hb814
`define DSHT_A_TATO 16'hb818
`define DSHT_A_RSTW 16'hb81c
`define DSHT_A_VSIZE 16'hb820
`define DSHT_A_WMARK 16'hb824
`define DSHT_A_HSW 16'hb828
`define DSHT_A_HBP 16'hb82c
`define DSHT_A_HFP 16'hb830
`define DSHT_A_HACT 16'hb834
`define DSHT_A_VSW 16'hb838
`define DSHT_A_VBP 16'hb83c
`define DSHT_A_VFP 16'hb840
`define DSHT_A_SWT 16'hb844
`define DSHT_A_SPCTL 16'hb848
`define DSHT_A_CMDB 16'hb84c
`define DSHT_FSET_RST 16'h0001
`define DSHT_FSET_MASK 16'he7ff
`define DSHT_STAT_MASK 32'h40e0_2dff
`define DSHT_ST_FIX 13
`define DSHT_ST_HSTO 21
`define DSHT_ST_LPTO 22
`define DSHT_ST_TATO 23
`define DSHT_ST_PKT 30
`define DSHT_SP_LPSEL 6
`define DSHT_SP_RST 7
`define DSHT_KIND_BLON 3'h4
`define DSHT_KIND_BLOFF 3'h5
`define DSHT_FIFO_DEPTH 8'h40
`define DSHT_WM_SEVEN 8'h07
`endif

// [dsht_link_timing.sv]
// Register file, timeouts, video timing and special packets of the display link port
// Functional notes
// - Acknowledge error interrupts gated by enable bits (the status mask drops bit 9, so that error never sets or interrupts)
// - Local single-bit fix interrupt needs bit 13
// - Command width field bits 15:13 encodings
// - Video pixel format field bits 10:7
// - Command packets use channel bits 6:5
// - Video packets use channel bits 4:3
// - Drive lane count from bits 2:0
// - High-speed timeout ends with EOT, stop
// - Low-power receive timeout enters stop state
// - Turnaround timeout enters stop state
// - Reset wait counts, then normal operation
// - Active size: lines high, pixels low (low half is not used; HACT sets active pixels)
// - Command stall released at selected watermark
// - Horizontal phases counted in byte clocks
// - Vertical phases counted in lines
// - Mode switch waits programmed byte clocks
// - Control bit 6 picks packet speed
// - Bit 5 sends backlight-off packet
// - High-speed timeout sets status bit 21
// - Bits 4..0 send their short packets
`timescale 1ns/1ps
`include "dsht_cfg.svh"
module dsht_link_timing (
	input wire logic mclk_in,
	input wire logic rst_b_in,
	input wire logic [15:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rdata_out,
	input wire logic byte_clk_in,
	input wire logic lp_rx_busy_in,
	input wire logic bta_wait_in,
	input wire logic [11:0] ack_err_in,
	input wire logic fix_err_in,
	input wire logic hs_req_in,
	input wire logic video_en_in,
	input wire logic [7:0] cmd_fifo_free_in,
	input wire logic pkt_ack_in,
	output logic irq_out,
	output logic [2:0] lane_count_out,
	output logic [1:0] cmd_vc_out,
	output logic [1:0] video_vc_out,
	output logic [2:0] cmd_width_out,
	output logic [3:0] pix_fmt_out,
	output logic cmd_stall_out,
	output logic lanes_hs_out,
	output logic eot_out,
	output logic stop_out,
	output logic periph_reset_out,
	output logic hsync_out,
	output logic vsync_out,
	output logic de_out,
	output logic pkt_req_out,
	output logic [2:0] pkt_kind_out,
	output logic [1:0] pkt_vc_out,
	output logic pkt_lp_out,
	output logic [5:0] pkt_cmd_out
);
	import dsht_pkg::*;

	typedef struct packed {
		logic [15:0] fset;
		logic [23:0] hs_to;
		logic [23:0] lp_to;
		logic [5:0] ta_to;
		logic [15:0] rst_w;
		logic [31:0] vsize;
		logic [1:0] wmark;
		logic [15:0] hsw;
		logic [15:0] hbp;
		logic [15:0] hfp;
		logic [15:0] hact;
		logic [15:0] vsw;
		logic [15:0] vbp;
		logic [15:0] vfp;
		logic [15:0] swt;
		logic [7:0] spctl;
		logic [5:0] cmdb;
		logic [31:0] ien;
		logic [31:0] stat;
		logic [31:0] rdata;
		logic irq;
		dsht_hph_t hph;
		dsht_vph_t vph;
		logic [15:0] hcnt;
		logic [15:0] vcnt;
		logic hsync;
		logic vsync;
		logic de;
		dsht_lane_t lane;
		logic [15:0] swcnt;
		logic eot;
		logic stop;
		logic stall;
		logic pkt_req;
		logic [2:0] pkt_kind;
		logic [5:0] pkt_cmd;
	} dsht_st_t;

	dsht_st_t s;
	dsht_st_t next_s;
	logic [2:0] pin_lvl;
	logic [2:0] pin_rise;
	logic hs_exp;
	logic lp_exp;
	logic ta_exp;
	logic rw_exp;
	logic hs_start;

	// Byte clock is sampled, not used as a clock
	dsht_sync u_sync (
		.mclk_in(mclk_in),
		.rst_b_in(rst_b_in),
		.pin_in({bta_wait_in, lp_rx_busy_in, byte_clk_in}),
		.level_out(pin_lvl),
		.rise_out(pin_rise)
	);

	wire logic tick = pin_rise[0];
	assign hs_start = (s.lane == LK_UP) && (next_s.lane == LK_HS);

	dsht_timeout u_hs_to (
		.mclk_in(mclk_in),
		.rst_b_in(rst_b_in),
		.tick_in(tick),
		.start_in(hs_start),
		.run_in(s.lane == LK_HS),
		.limit_in(s.hs_to),
		.expired_out(hs_exp)
	);

	dsht_timeout u_lp_to (
		.mclk_in(mclk_in),
		.rst_b_in(rst_b_in),
		.tick_in(tick),
		.start_in(pin_rise[1]),
		.run_in(pin_lvl[1]),
		.limit_in(s.lp_to),
		.expired_out(lp_exp)
	);

	dsht_timeout u_ta_to (
		.mclk_in(mclk_in),
		.rst_b_in(rst_b_in),
		.tick_in(tick),
		.start_in(pin_rise[2]),
		.run_in(pin_lvl[2]),
		.limit_in({18'h0_0000, s.ta_to}),
		.expired_out(ta_exp)
	);

	dsht_timeout u_rw_to (
		.mclk_in(mclk_in),
		.rst_b_in(rst_b_in),
		.tick_in(tick),
		.start_in(wr_in && addr_in == `DSHT_A_SPCTL && wdata_in[`DSHT_SP_RST]),
		.run_in(s.spctl[`DSHT_SP_RST]),
		.limit_in({8'h00, s.rst_w}),
		.expired_out(rw_exp)
	);

	// Length of each horizontal phase in byte ticks
	function automatic logic [15:0] hlen(input dsht_hph_t p, input dsht_st_t r);
		unique case (p)
			H_SYNC: hlen = r.hsw;
			H_BP: hlen = r.hbp;
			H_ACT: hlen = r.hact;
			H_FP: hlen = r.hfp;
		endcase
	endfunction : hlen

	// Length of each vertical phase in lines
	function automatic logic [15:0] vlen(input dsht_vph_t p, input dsht_st_t r);
		unique case (p)
			V_SYNC: vlen = r.vsw;
			V_BP: vlen = r.vbp;
			V_ACT: vlen = r.vsize[31:16];
			V_FP: vlen = r.vfp;
		endcase
	endfunction : vlen

	// Free entries that release the command stall
	function automatic logic [7:0] wm_level(input logic [1:0] sel);
		unique case (sel)
			2'b00: wm_level = `DSHT_FIFO_DEPTH >> 1;
			2'b01: wm_level = `DSHT_FIFO_DEPTH >> 2;
			2'b10: wm_level = `DSHT_WM_SEVEN;
			// Reserved code kept safe at half empty
			2'b11: wm_level = `DSHT_FIFO_DEPTH >> 1;
		endcase
	endfunction : wm_level

	logic [31:0] st_set;
	logic [31:0] st_clr;
	logic [31:0] rd_mux;
	logic line_end;
	always_comb begin
		next_s = s;
		st_set = 32'h0000_0000;
		st_clr = 32'h0000_0000;
		rd_mux = 32'h0000_0000;
		line_end = 1'b0;
		next_s.eot = 1'b0;
		next_s.stop = 1'b0;

		// Register writes
		if (wr_in) begin
			unique case (addr_in)
				`DSHT_A_STAT: st_clr = wdata_in;
				`DSHT_A_IEN: next_s.ien = wdata_in & `DSHT_STAT_MASK;
				`DSHT_A_FSET: next_s.fset = wdata_in[15:0] & `DSHT_FSET_MASK;
				`DSHT_A_HSTO: next_s.hs_to = wdata_in[23:0];
				`DSHT_A_LPTO: next_s.lp_to = wdata_in[23:0];
				`DSHT_A_TATO: next_s.ta_to = wdata_in[5:0];
				`DSHT_A_RSTW: next_s.rst_w = wdata_in[15:0];
				`DSHT_A_VSIZE: next_s.vsize = wdata_in;
				`DSHT_A_WMARK: next_s.wmark = wdata_in[1:0];
				`DSHT_A_HSW: next_s.hsw = wdata_in[15:0];
				`DSHT_A_HBP: next_s.hbp = wdata_in[15:0];
				`DSHT_A_HFP: next_s.hfp = wdata_in[15:0];
				`DSHT_A_HACT: next_s.hact = wdata_in[15:0];
				`DSHT_A_VSW: next_s.vsw = wdata_in[15:0];
				`DSHT_A_VBP: next_s.vbp = wdata_in[15:0];
				`DSHT_A_VFP: next_s.vfp = wdata_in[15:0];
				`DSHT_A_SWT: next_s.swt = wdata_in[15:0];
				`DSHT_A_SPCTL: begin
					// Trigger bits only accumulate; hardware clears them when sent
					next_s.spctl[5:0] = s.spctl[5:0] | wdata_in[5:0];
					next_s.spctl[`DSHT_SP_LPSEL] = wdata_in[`DSHT_SP_LPSEL];
					next_s.spctl[`DSHT_SP_RST] = s.spctl[`DSHT_SP_RST] | wdata_in[`DSHT_SP_RST];
				end
				`DSHT_A_CMDB: next_s.cmdb = wdata_in[5:0];
				default: ;
			endcase
		end

		// Read data stands one cycle after the strobe only
		unique case (addr_in)
			`DSHT_A_STAT: rd_mux = s.stat;
			`DSHT_A_IEN: rd_mux = s.ien;
			`DSHT_A_FSET: rd_mux = {16'h0000, s.fset};
			`DSHT_A_HSTO: rd_mux = {8'h00, s.hs_to};
			`DSHT_A_LPTO: rd_mux = {8'h00, s.lp_to};
			`DSHT_A_TATO: rd_mux = {26'h000_0000, s.ta_to};
			`DSHT_A_RSTW: rd_mux = {16'h0000, s.rst_w};
			`DSHT_A_VSIZE: rd_mux = s.vsize;
			`DSHT_A_WMARK: rd_mux = {30'h0000_0000, s.wmark};
			`DSHT_A_HSW: rd_mux = {16'h0000, s.hsw};
			`DSHT_A_HBP: rd_mux = {16'h0000, s.hbp};
			`DSHT_A_HFP: rd_mux = {16'h0000, s.hfp};
			`DSHT_A_HACT: rd_mux = {16'h0000, s.hact};
			`DSHT_A_VSW: rd_mux = {16'h0000, s.vsw};
			`DSHT_A_VBP: rd_mux = {16'h0000, s.vbp};
			`DSHT_A_VFP: rd_mux = {16'h0000, s.vfp};
			`DSHT_A_SWT: rd_mux = {16'h0000, s.swt};
			`DSHT_A_SPCTL: rd_mux = {24'h00_0000, s.spctl};
			`DSHT_A_CMDB: rd_mux = {26'h000_0000, s.cmdb};
			default: rd_mux = 32'h0000_0000;
		endcase
		next_s.rdata = rd_in ? rd_mux : 32'h0000_0000;

		// Lane mode sequencing with switch time
		unique case (s.lane)
			LK_LP: begin
				if (hs_req_in) begin
					next_s.lane = LK_UP;
					next_s.swcnt = 16'h0000;
				end
			end
			LK_UP: begin
				if (tick) begin
					if (s.swcnt >= s.swt) begin
						next_s.lane = LK_HS;
					end else begin
						next_s.swcnt = s.swcnt + 16'h0001;
					end
				end
			end
			LK_HS: begin
				if (hs_exp) begin
					next_s.eot = 1'b1;
					next_s.lane = LK_DN;
					next_s.swcnt = 16'h0000;
				end else if (!hs_req_in) begin
					next_s.lane = LK_DN;
					next_s.swcnt = 16'h0000;
				end
			end
			LK_DN: begin
				if (tick) begin
					if (s.swcnt >= s.swt) begin
						next_s.lane = LK_LP;
					end else begin
						next_s.swcnt = s.swcnt + 16'h0001;
					end
				end
			end
		endcase
		next_s.stop = hs_exp | lp_exp | ta_exp;

		// Peripheral reset wait ends on expiry; a fresh start in that cycle wins
		if (rw_exp && !(wr_in && addr_in == `DSHT_A_SPCTL && wdata_in[`DSHT_SP_RST])) begin
			next_s.spctl[`DSHT_SP_RST] = 1'b0;
		end

		// Video timing on byte ticks
		if (!video_en_in) begin
			next_s.hph = H_SYNC;
			next_s.vph = V_SYNC;
			next_s.hcnt = 16'h0000;
			next_s.vcnt = 16'h0000;
		end else if (tick) begin
			if (s.hcnt + 16'h0001 >= hlen(s.hph, s)) begin
				next_s.hcnt = 16'h0000;
				unique case (s.hph)
					H_SYNC: next_s.hph = H_BP;
					H_BP: next_s.hph = H_ACT;
					H_ACT: next_s.hph = H_FP;
					H_FP: begin
						next_s.hph = H_SYNC;
						line_end = 1'b1;
					end
				endcase
			end else begin
				next_s.hcnt = s.hcnt + 16'h0001;
			end
		end
		if (line_end) begin
			if (s.vcnt + 16'h0001 >= vlen(s.vph, s)) begin
				next_s.vcnt = 16'h0000;
				unique case (s.vph)
					V_SYNC: next_s.vph = V_BP;
					V_BP: next_s.vph = V_ACT;
					V_ACT: next_s.vph = V_FP;
					V_FP: next_s.vph = V_SYNC;
				endcase
			end else begin
				next_s.vcnt = s.vcnt + 16'h0001;
			end
		end
		next_s.hsync = video_en_in && next_s.hph == H_SYNC;
		next_s.vsync = video_en_in && next_s.vph == V_SYNC;
		next_s.de = video_en_in && next_s.hph == H_ACT && next_s.vph == V_ACT;

		// Special short packets, lowest pending bit first
		if (s.pkt_req) begin
			if (pkt_ack_in) begin
				next_s.pkt_req = 1'b0;
				next_s.spctl[s.pkt_kind] = 1'b0;
				st_set[`DSHT_ST_PKT] = 1'b1;
			end
		end else begin
			for (int k = 5; k >= 0; k--) begin
				if (s.spctl[k]) begin
					next_s.pkt_req = 1'b1;
					next_s.pkt_kind = 3'(k);
				end
			end
			// Command byte was loaded beforehand by software
			next_s.pkt_cmd = (next_s.pkt_kind == `DSHT_KIND_BLON ||
				next_s.pkt_kind == `DSHT_KIND_BLOFF) ? s.cmdb : 6'h00;
		end

		next_s.stall = cmd_fifo_free_in < wm_level(s.wmark);

		// Sticky status; a set in the clearing cycle wins
		st_set[11:0] = ack_err_in;
		st_set[`DSHT_ST_FIX] = fix_err_in;
		st_set[`DSHT_ST_HSTO] = hs_exp;
		st_set[`DSHT_ST_LPTO] = lp_exp;
		st_set[`DSHT_ST_TATO] = ta_exp;
		next_s.stat = ((s.stat & ~st_clr) | st_set) & `DSHT_STAT_MASK;
		next_s.irq = |(s.stat & s.ien);
	end

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			s <= '0;
			s.fset <= `DSHT_FSET_RST;
			s.hph <= H_SYNC;
			s.vph <= V_SYNC;
			s.lane <= LK_LP;
		end else begin
			s <= next_s;
		end
	end

	assign rdata_out = s.rdata;
	assign irq_out = s.irq;
	assign lane_count_out = s.fset[2:0];
	assign cmd_vc_out = s.fset[6:5];
	assign video_vc_out = s.fset[4:3];
	assign cmd_width_out = s.fset[15:13];
	assign pix_fmt_out = s.fset[10:7];
	assign cmd_stall_out = s.stall;
	// One-hot code bit keeps this output straight from a flop
	assign lanes_hs_out = s.lane[2];
	assign eot_out = s.eot;
	assign stop_out = s.stop;
	assign periph_reset_out = s.spctl[`DSHT_SP_RST];
	assign hsync_out = s.hsync;
	assign vsync_out = s.vsync;
	assign de_out = s.de;
	assign pkt_req_out = s.pkt_req;
	assign pkt_kind_out = s.pkt_kind;
	assign pkt_vc_out = s.fset[4:3];
	assign pkt_lp_out = s.spctl[`DSHT_SP_LPSEL];
	assign pkt_cmd_out = s.pkt_cmd;
endmodule : dsht_link_timing

// [dsht_link_timing_chk.sv]
// Port assertions of the link timing block
`timescale 1ns/1ps
`include "dsht_cfg.svh"
module dsht_link_timing_chk (
	input wire logic mclk_in,
	input wire logic rst_b_in,
	input wire logic [15:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic video_en_in,
	input wire logic [7:0] cmd_fifo_free_in,
	input wire logic pkt_ack_in,
	input wire logic [2:0] lane_count_out,
	input wire logic [1:0] cmd_vc_out,
	input wire logic [1:0] video_vc_out,
	input wire logic [2:0] cmd_width_out,
	input wire logic [3:0] pix_fmt_out,
	input wire logic cmd_stall_out,
	input wire logic eot_out,
	input wire logic stop_out,
	input wire logic periph_reset_out,
	input wire logic de_out,
	input wire logic pkt_req_out,
	input wire logic [1:0] pkt_vc_out
);
	logic [1:0] wm_sel;
	logic [7:0] wm_lvl;
	logic below;
	// Shadow select moves on the same edge as the block's own copy
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wm_sel <= 2'h0;
			below <= 1'b0;
		end else begin
			below <= cmd_fifo_free_in < wm_lvl;
			if (wr_in && addr_in == `DSHT_A_WMARK)
				wm_sel <= wdata_in[1:0];
		end
	end
	assign wm_lvl = (wm_sel == 2'h1) ? 8'h10 : (wm_sel == 2'h2) ? 8'h07 : 8'h20;
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_b_in);
	fields_a:
	assert property ($past(wr_in, 2) && $past(addr_in, 2) == `DSHT_A_FSET
		&& !($past(wr_in) && $past(addr_in) == `DSHT_A_FSET) |->
		{16'h0000, cmd_width_out, 2'h0, pix_fmt_out, cmd_vc_out, video_vc_out, lane_count_out}
		== ($past(wdata_in, 2) & 32'h0000_e7ff)) else $error("setup fields wrong");
	stall_lvl_a:
	assert property (cmd_stall_out == below) else $error("stall level wrong");
	pkt_hold_a:
	assert property (pkt_req_out && !pkt_ack_in |=> pkt_req_out) else $error("request lost");
	pkt_drop_a:
	assert property (pkt_req_out && pkt_ack_in |=> !pkt_req_out) else $error("request kept");
	pkt_vc_a:
	assert property (pkt_req_out |-> pkt_vc_out == video_vc_out) else $error("packet channel");
	stop_pulse_a:
	assert property (stop_out |=> !stop_out) else $error("stop not a pulse");
	eot_stop_a:
	assert property (eot_out |-> ##[0:1] stop_out) else $error("eot without stop");
	rst_wait_a:
	assert property ($rose(periph_reset_out) |-> $past(wr_in) && $past(addr_in) == `DSHT_A_SPCTL)
		else $error("reset wait without write");
	video_off_a:
	assert property (!video_en_in [*2] |-> !de_out) else $error("active with video off");
endmodule : dsht_link_timing_chk
bind dsht_link_timing dsht_link_timing_chk dsht_link_timing_chk_i (.mclk_in, .rst_b_in,
	.addr_in, .wdata_in, .wr_in, .video_en_in, .cmd_fifo_free_in, .pkt_ack_in, .lane_count_out,
	.cmd_vc_out, .video_vc_out, .cmd_width_out, .pix_fmt_out, .cmd_stall_out, .eot_out,
	.stop_out, .periph_reset_out, .de_out, .pkt_req_out, .pkt_vc_out);

// [dsht_periph_model.sv]
// Display peripheral model: byte clock and special packet acceptance
`timescale 1ns/1ps
module dsht_periph_model (
	input wire logic mclk_in,
	input wire logic rst_b_in,
	input wire logic run_in,
	input wire logic pkt_req_in,
	input wire logic [3:0] ack_dly_in,
	output logic byte_clk_out,
	output logic pkt_ack_out
);
	logic [3:0] wait_cnt;
	// Free running byte clock, phase unrelated to the system clock
	initial begin
		byte_clk_out = 1'b0;
		#37;
		forever #80 byte_clk_out = run_in ? ~byte_clk_out : 1'b0;
	end
	// Slow acceptance when a delay is chosen
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wait_cnt <= 4'h0;
			pkt_ack_out <= 1'b0;
		end else if (pkt_ack_out) begin
			wait_cnt <= 4'h0;
			pkt_ack_out <= 1'b0;
		end else if (pkt_req_in) begin
			if (wait_cnt >= ack_dly_in)
				pkt_ack_out <= 1'b1;
			else
				wait_cnt <= wait_cnt + 4'h1;
		end
	end
endmodule : dsht_periph_model

// [dsht_pkg.sv]
// Types shared by the link timing block
package dsht_pkg;
	typedef enum logic [3:0] {
		H_SYNC = 4'b0001,
		H_BP = 4'b0010,
		H_ACT = 4'b0100,
		H_FP = 4'b1000
	} dsht_hph_t;
	typedef enum logic [3:0] {
		V_SYNC = 4'b0001,
		V_BP = 4'b0010,
		V_ACT = 4'b0100,
		V_FP = 4'b1000
	} dsht_vph_t;
	typedef enum logic [3:0] {
		LK_LP = 4'b0001,
		LK_UP = 4'b0010,
		LK_HS = 4'b0100,
		LK_DN = 4'b1000
	} dsht_lane_t;
endpackage : dsht_pkg

// [dsht_sync.sv]
// Two-flop synchroniser with rising-edge pulse for link pins
`timescale 1ns/1ps
module dsht_sync (
	input wire logic mclk_in,
	input wire logic rst_b_in,
	input wire logic [2:0] pin_in,
	output logic [2:0] level_out,
	output logic [2:0] rise_out
);
	typedef struct packed {
		logic [2:0] meta;
		logic [2:0] sync;
		logic [2:0] prev;
	} dsht_sync_st_t;
	dsht_sync_st_t s;
	dsht_sync_st_t next_s;
	// Meta stage feeds only the second stage
	always_comb begin
		next_s.meta = pin_in;
		next_s.sync = s.meta;
		// Edge found one stage later so the meta flop has one reader
		next_s.prev = s.sync;
	end
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
	assign level_out = s.sync;
	assign rise_out = s.sync & ~s.prev;
endmodule : dsht_sync

// [dsht_timeout.sv]
// Supervision timer counting link byte ticks against a programmed limit
`timescale 1ns/1ps
module dsht_timeout (
	input wire logic mclk_in,
	input wire logic rst_b_in,
	input wire logic tick_in,
	input wire logic start_in,
	input wire logic run_in,
	input wire logic [23:0] limit_in,
	output logic expired_out
);
	typedef struct packed {
		logic [23:0] cnt;
		logic done;
		logic expired;
	} dsht_to_st_t;
	dsht_to_st_t s;
	dsht_to_st_t next_s;
	always_comb begin
		next_s = s;
		next_s.expired = 1'b0;
		if (start_in) begin
			next_s.cnt = 24'h00_0000;
			next_s.done = 1'b0;
		end else if (run_in && tick_in && !s.done) begin
			if (s.cnt >= limit_in) begin
				next_s.expired = 1'b1;
				next_s.done = 1'b1;
			end else begin
				next_s.cnt = s.cnt + 24'h00_0001;
			end
		end
	end
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
	assign expired_out = s.expired;
endmodule : dsht_timeout

// [tb_dsht_link_timing.sv]
// Self-checking bench of the link timing block
`timescale 1ns/1ps
`include "dsht_cfg.svh"
module tb_dsht_link_timing;
	logic mclk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic fix_err_in = 1'b0;
	logic hs_req_in = 1'b0;
	logic video_en_in = 1'b0;
	logic lp_rx_busy_in = 1'b0;
	logic bta_wait_in = 1'b0;
	logic run = 1'b0;
	logic [15:0] addr_in = 16'h0000;
	logic [31:0] wdata_in = 32'h0000_0000;
	logic [11:0] ack_err_in = 12'h000;
	logic [7:0] cmd_fifo_free_in = 8'h40;
	logic [3:0] dly = 4'h0;
	logic [31:0] rdata_out, d, e;
	logic byte_clk_in, pkt_ack_in, irq_out, cmd_stall_out, lanes_hs_out, eot_out, stop_out;
	logic periph_reset_out, hsync_out, vsync_out, de_out, pkt_req_out, pkt_lp_out;
	logic [2:0] lane_count_out, cmd_width_out, pkt_kind_out;
	logic [1:0] cmd_vc_out, video_vc_out, pkt_vc_out;
	logic [3:0] pix_fmt_out;
	logic [5:0] pkt_cmd_out, c;
	int n_mismatch = 0;
	int num_checks = 0;
	int cyc = 0;
	int k, t, t0;
	initial begin
		forever #5 mclk_in = ~mclk_in;
	end
	dsht_link_timing dsht_link_timing_i (.mclk_in, .rst_b_in, .addr_in, .wdata_in, .wr_in,
		.rd_in, .rdata_out, .byte_clk_in, .lp_rx_busy_in, .bta_wait_in, .ack_err_in, .fix_err_in,
		.hs_req_in, .video_en_in, .cmd_fifo_free_in, .pkt_ack_in, .irq_out, .lane_count_out,
		.cmd_vc_out, .video_vc_out, .cmd_width_out, .pix_fmt_out, .cmd_stall_out, .lanes_hs_out,
		.eot_out, .stop_out, .periph_reset_out, .hsync_out, .vsync_out, .de_out, .pkt_req_out,
		.pkt_kind_out, .pkt_vc_out, .pkt_lp_out, .pkt_cmd_out);
	dsht_periph_model dsht_periph_model_i (.mclk_in, .rst_b_in, .run_in(run),
		.pkt_req_in(pkt_req_out), .ack_dly_in(dly), .byte_clk_out(byte_clk_in),
		.pkt_ack_out(pkt_ack_in));
	task automatic report_and_stop;
		$display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : report_and_stop
	always @(posedge mclk_in) begin
		cyc++;
		if (cyc == 50000) begin
			n_mismatch++;
			report_and_stop();
		end
	end
	task automatic chk(input logic ok, input string m);
		num_checks++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("Error at %0t ns: %s", $time, m);
		end
	endtask : chk
	task automatic step(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask : step
	task automatic wr(input logic [15:0] a, input logic [31:0] v);
		@(posedge mclk_in);
		addr_in <= a;
		wdata_in <= v;
		wr_in <= 1'b1;
		@(posedge mclk_in);
		wr_in <= 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] a, output logic [31:0] v);
		@(posedge mclk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge mclk_in);
		rd_in <= 1'b0;
		#1;
		v = rdata_out;
	endtask : rd
	task automatic wait_lvl(ref logic s, input logic v);
		int i;
		#1;
		for (i = 0; i < 3000 && s !== v; i++)
			step(1);
		chk(s === v, "awaited level missing");
	endtask : wait_lvl
	function automatic logic [7:0] wm_lvl(input logic [1:0] s);
		return (s == 2'h1) ? 8'h10 : (s == 2'h2) ? 8'h07 : 8'h20;
	endfunction : wm_lvl
	initial begin
		void'($urandom(32'hb218));
		repeat (10) @(posedge mclk_in);
		rst_b_in <= 1'b1;
		run <= 1'b1;
		for (k = 0; k < 18; k++) begin
			rd(16'hb80c + 16'(4 * k), e);
			chk(e === ((k == 0) ? 32'h0000_0001 : 32'h0000_0000), "reset value");
		end
		for (k = 0; k < 16; k++) begin
			d = $urandom();
			wr((k < 15) ? 16'hb80c + 16'(4 * k) : 16'hb900, d);
			rd((k < 15) ? 16'hb80c + 16'(4 * k) : 16'hb900, e);
			chk(e === (d & ((k == 0) ? 32'h0000_e7ff : (k < 3) ? 32'h00ff_ffff : (k == 3)
				? 32'h0000_003f : (k == 5) ? 32'hffff_ffff : (k == 6) ? 32'h0000_0003
				: (k < 15) ? 32'h0000_ffff : 32'h0000_0000)), "readback");
		end
		$display("Test done: registers");
		for (k = 1; k < 6; k++) begin
			d = {16'h0000, 3'(k), 2'h0, 4'(k), 2'(k), 2'(k + 1), 3'(k)};
			wr(`DSHT_A_FSET, d);
			step(2);
			chk({cmd_width_out, pix_fmt_out, cmd_vc_out, video_vc_out, lane_count_out} === {3'(k),
				4'(k), 2'(k), 2'(k + 1), 3'(k)}, "setup field");
		end
		for (k = 0; k < 4; k++) begin
			wr(`DSHT_A_WMARK, 32'(k));
			for (t = 0; t < 2; t++) begin
				cmd_fifo_free_in <= wm_lvl(2'(k)) - 8'(t);
				step(3);
				chk(cmd_stall_out === (t == 1), "stall");
			end
		end
		cmd_fifo_free_in <= 8'h40;
		$display("Test done: fields");
		for (k = 0; k < 14; k++) begin
			d = $urandom();
			wr(`DSHT_A_IEN, d);
			ack_err_in <= (k < 12) ? 12'(1 << k) : 12'h000;
			fix_err_in <= (k == 13);
			step(1);
			ack_err_in <= 12'h000;
			fix_err_in <= 1'b0;
			step(3);
			chk(irq_out === (d[k] && k != 9 && k != 12), "irq");
			wr(`DSHT_A_STAT, 32'hffff_ffff);
			step(3);
			chk(irq_out === 1'b0, "irq clear");
		end
		$display("Test done: interrupts");
		for (k = 0; k < 4; k++) begin
			c = 6'($urandom());
			d = ($urandom() & 32'h0000_007f) | 32'h0000_0001;
			dly <= 4'($urandom());
			wr(`DSHT_A_CMDB, 32'(c));
			wr(`DSHT_A_SPCTL, d);
			for (t = 0; t < 6; t++) begin
				if (d[t]) begin
					wait_lvl(pkt_req_out, 1'b1);
					chk({pkt_kind_out, pkt_lp_out, pkt_cmd_out, pkt_vc_out} === {3'(t), d[6],
						(t > 3) ? c : 6'h00, 2'h2}, "packet");
					wait_lvl(pkt_req_out, 1'b0);
				end
			end
		end
		rd(`DSHT_A_STAT, e);
		chk(e[30] === 1'b1, "packet sent status");
		$display("Test done: packets");
		wr(`DSHT_A_SWT, 32'h0000_0001);
		wr(`DSHT_A_HSTO, 32'h0000_0003);
		hs_req_in <= 1'b1;
		wait_lvl(lanes_hs_out, 1'b1);
		t0 = cyc;
		wait_lvl(eot_out, 1'b1);
		hs_req_in <= 1'b0;
		chk((cyc - t0) inside {[40:90]}, "hs timeout length");
		rd(`DSHT_A_STAT, e);
		chk(e[21] === 1'b1, "hs timeout status");
		wr(`DSHT_A_LPTO, 32'h0000_0002);
		wr(`DSHT_A_TATO, 32'h0000_0002);
		for (k = 0; k < 4; k++) begin
			lp_rx_busy_in <= (k < 2);
			bta_wait_in <= (k > 1);
			t0 = cyc;
			wait_lvl(stop_out, 1'b1);
			chk((cyc - t0) inside {[24:72]}, "rx timeout length");
			lp_rx_busy_in <= 1'b0;
			bta_wait_in <= 1'b0;
			step(4);
		end
		rd(`DSHT_A_STAT, e);
		chk(e[23:22] === 2'h3, "rx timeout status");
		$display("Test done: timeouts");
		wr(`DSHT_A_RSTW, 32'h0000_0002);
		wr(`DSHT_A_SPCTL, 32'h0000_0080);
		t0 = cyc;
		step(1);
		chk(periph_reset_out === 1'b1, "reset wait start");
		wait_lvl(periph_reset_out, 1'b0);
		chk((cyc - t0) inside {[24:72]}, "reset wait length");
		$display("Test done: reset wait");
		wr(`DSHT_A_VSIZE, 32'h0002_0004);
		for (k = 0; k < 7; k++)
			wr(16'hb828 + 16'(4 * k), (k == 3) ? 32'h0000_0003 : 32'h0000_0001);
		video_en_in <= 1'b1;
		wait_lvl(de_out, 1'b1);
		t0 = cyc;
		wait_lvl(de_out, 1'b0);
		chk((cyc - t0) inside {[44:52]}, "active length");
		t0 = cyc;
		wait_lvl(hsync_out, 1'b1);
		chk((cyc - t0) inside {[12:20]}, "front porch length");
		wait_lvl(vsync_out, 1'b1);
		video_en_in <= 1'b0;
		$display("Test done: video");
		report_and_stop();
	end
endmodule : tb_dsht_link_timing
